//--- rtl/sioc_top.sv
`timescale 1ns/1ps
module sioc_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // serial data out pin (port1 bit5)
    output logic             port1_bit5_pin_o,
    output logic             port1_bit5_pin_oe_o,
    // shift clock pin (port1 bit6)
    input  wire logic        port1_bit6_pin_i,
    output logic             port1_bit6_pin_o,
    output logic             port1_bit6_pin_oe_o,
    // ready handshake pin (port1 bit7)
    output logic             port1_bit7_pin_o,
    output logic             port1_bit7_pin_oe_o,
    // serial data in
    input  wire logic        sin_i,
    // asynchronous error events from the receive framer
    input  wire logic        parity_err_i,
    input  wire logic        framing_err_i,
    // ordinary port latch and direction when pins are not serial
    input  wire logic [2:0]  port_dat_i,
    input  wire logic [2:0]  port_dir_i,
    // interrupt
    output logic             irq_o
);
    // complete block state except the prescaler counter, which sioc_div keeps
    typedef struct packed {
        logic [7:0]                 ctrl;     // serial_port_control
        logic [6:0]                 status;   // serial_port_status bits 6..0
        logic [7:0]                 txbuf;    // transmit buffer
        logic [7:0]                 shreg;    // shift register
        logic [7:0]                 rxbuf;    // receive buffer
        logic [2:0]                 bitcnt;   // bits shifted
        logic                       sclk;     // internal clock level
        logic                       ext_d;    // previous external clock level
        sioc_pkg::sioc_state_t      fsm;      // shift sequence
        logic [sioc_pkg::EV_W-1:0]  ev_st;    // sticky events
        logic [sioc_pkg::EV_W-1:0]  ev_en;    // event enables
        logic                       pend;     // written byte not yet shifted
        logic                       ack;      // bus ack
        logic [31:0]                rdat;     // bus read data
    } sioc_st_t;

    sioc_st_t          st_r;    // state
    sioc_st_t          st_nxt;  // next state
    logic              tick;    // prescaler tick
    logic              wr_acc;  // bus write this cycle
    logic              rd_acc;  // bus read this cycle
    logic              edge_lo; // falling shift edge: unused, data moves on the rising edge
    logic              edge_hi; // rising shift edge: sample data
    logic [7:0]        st_rd;   // visible status byte
    sioc_pkg::sioc_pins_t pins; // raw pin levels

    // variant switch kept local so the sequencer reads it as a constant
    localparam bit UART_ERR_OK = sioc_pkg::UART_VARIANT;

    // prescaler runs only with internal clock during a shift
    sioc_div u_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .sel_i  (st_r.ctrl[sioc_pkg::CTRL_DIV_LSB +: 2]),
        .run_i  (st_r.ctrl[sioc_pkg::CTRL_INTCLK] && st_r.fsm == sioc_pkg::SIOC_SHIFT),
        .tick_o (tick)
    );

    // classic wishbone: one-cycle ack, dropped the cycle after
    assign wr_acc = cyc_i && stb_i && we_i && !st_r.ack;
    assign rd_acc = cyc_i && stb_i && !we_i && !st_r.ack;

    // shift edges: internal clock toggles on tick, external is edge detected
    always_comb begin
        if (st_r.ctrl[sioc_pkg::CTRL_INTCLK]) begin
            edge_lo = tick && st_r.sclk;
            edge_hi = tick && !st_r.sclk;
        end else begin
            edge_lo = st_r.ext_d && !port1_bit6_pin_i;
            edge_hi = !st_r.ext_d && port1_bit6_pin_i;
        end
    end

    // visible status byte; bit 7 is hard-wired one
    always_comb begin
        st_rd                   = {1'b1, st_r.status};
        st_rd[sioc_pkg::ST_ANY_ERR] = |st_r.status[sioc_pkg::ST_FRM_ERR:sioc_pkg::ST_OE];
    end

    // next-state logic
    always_comb begin
        st_nxt       = st_r;
        st_nxt.ack   = 1'b0;
        st_nxt.ext_d = port1_bit6_pin_i;
        // bus writes
        if (wr_acc) begin
            st_nxt.ack = 1'b1;
            if (sel_i[0]) begin
                if (adr_i == sioc_pkg::ADDR_CTRL) begin
                    st_nxt.ctrl = dat_i[7:0];
                end else if (adr_i == sioc_pkg::ADDR_TXDATA) begin
                    st_nxt.txbuf                  = dat_i[7:0];
                    st_nxt.status[sioc_pkg::ST_TX_EMPTY] = 1'b0;
                    // the empty flag resets low, so a separate bit marks real data
                    st_nxt.pend                   = 1'b1;
                end else if (adr_i == sioc_pkg::ADDR_IRQ_EN) begin
                    st_nxt.ev_en = dat_i[sioc_pkg::EV_W-1:0];
                end else if (adr_i == sioc_pkg::ADDR_IRQ_CLR) begin
                    st_nxt.ev_st = st_r.ev_st & ~dat_i[sioc_pkg::EV_W-1:0];
                end
                // status writes are ignored entirely
            end
        end
        // bus reads; reading the receive buffer empties it and clears errors
        if (rd_acc) begin
            st_nxt.ack  = 1'b1;
            st_nxt.rdat = 32'h0000_0000;
            if (adr_i == sioc_pkg::ADDR_CTRL) begin
                st_nxt.rdat[7:0] = st_r.ctrl;
            end else if (adr_i == sioc_pkg::ADDR_STATUS) begin
                st_nxt.rdat[7:0] = st_rd;
            end else if (adr_i == sioc_pkg::ADDR_RXDATA) begin
                st_nxt.rdat[7:0]                   = st_r.rxbuf;
                st_nxt.status[sioc_pkg::ST_RX_FULL] = 1'b0;
                st_nxt.status[sioc_pkg::ST_FRM_ERR:sioc_pkg::ST_OE] = 3'h0;
            end else if (adr_i == sioc_pkg::ADDR_IRQ_ST) begin
                st_nxt.rdat[sioc_pkg::EV_W-1:0] = st_r.ev_st;
            end else if (adr_i == sioc_pkg::ADDR_IRQ_EN) begin
                st_nxt.rdat[sioc_pkg::EV_W-1:0] = st_r.ev_en;
            end
            // unmapped and write-only offsets read zero
        end
        // shift sequencer; hardware sets win over software clears above
        case (st_r.fsm)
            sioc_pkg::SIOC_IDLE: begin
                st_nxt.sclk = 1'b1;
                if (st_r.pend && st_r.ctrl[sioc_pkg::CTRL_SIO_PINS]) begin
                    st_nxt.shreg                    = st_r.txbuf;
                    st_nxt.pend                     = 1'b0;
                    st_nxt.status[sioc_pkg::ST_TX_EMPTY] = 1'b1;
                    st_nxt.status[sioc_pkg::ST_TX_DONE]  = 1'b0;
                    st_nxt.bitcnt                   = 3'h0;
                    st_nxt.fsm                      = sioc_pkg::SIOC_SHIFT;
                end
            end
            sioc_pkg::SIOC_SHIFT: begin
                if (st_r.ctrl[sioc_pkg::CTRL_INTCLK] && tick) begin
                    st_nxt.sclk = !st_r.sclk;
                end
                // lsb first: capture and move on the rising edge
                if (edge_hi) begin
                    st_nxt.shreg = {sin_i, st_r.shreg[7:1]};
                    if (st_r.bitcnt == 3'h7) begin
                        st_nxt.fsm = sioc_pkg::SIOC_DONE;
                    end else begin
                        st_nxt.bitcnt = st_r.bitcnt + 3'h1;
                    end
                end
            end
            default: begin
                st_nxt.sclk                     = 1'b1;
                st_nxt.status[sioc_pkg::ST_TX_DONE] = 1'b1;
                st_nxt.rxbuf                    = st_r.shreg;
                if (st_r.status[sioc_pkg::ST_RX_FULL] && UART_ERR_OK) begin
                    st_nxt.status[sioc_pkg::ST_OE] = 1'b1;
                end
                st_nxt.status[sioc_pkg::ST_RX_FULL] = 1'b1;
                st_nxt.ev_st[sioc_pkg::EV_TX_DONE] = 1'b1;
                st_nxt.ev_st[sioc_pkg::EV_RX_FULL] = 1'b1;
                st_nxt.fsm                      = sioc_pkg::SIOC_IDLE;
            end
        endcase
        // asynchronous error flags exist only in the uart variant
        if (UART_ERR_OK && parity_err_i) begin
            st_nxt.status[sioc_pkg::ST_PAR_ERR] = 1'b1;
        end
        if (UART_ERR_OK && framing_err_i) begin
            st_nxt.status[sioc_pkg::ST_FRM_ERR] = 1'b1;
        end
        if (|st_nxt.status[sioc_pkg::ST_FRM_ERR:sioc_pkg::ST_OE]) begin
            st_nxt.ev_st[sioc_pkg::EV_ERROR] = 1'b1;
        end
        st_nxt.status[sioc_pkg::ST_ANY_ERR] =
            |st_nxt.status[sioc_pkg::ST_FRM_ERR:sioc_pkg::ST_OE];
        // byte specify mode is absent in the uart variant
        if (UART_ERR_OK) begin
            st_nxt.ctrl[sioc_pkg::CTRL_BYTE_SPC] = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r        <= '0;
            st_r.ctrl   <= sioc_pkg::CTRL_RESET;
            st_r.status <= sioc_pkg::STATUS_RESET;
            st_r.sclk   <= 1'b1;
            st_r.ext_d  <= 1'b1;
            st_r.fsm    <= sioc_pkg::SIOC_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // raw serial levels before pin muxing
    always_comb begin
        pins.sout     = st_r.fsm == sioc_pkg::SIOC_SHIFT ? st_r.shreg[0] : 1'b1;
        pins.sclk_out = st_r.sclk;
        pins.sclk_oe  = st_r.ctrl[sioc_pkg::CTRL_INTCLK];
        // normal ready: low when armed; alternative: high when armed
        pins.rdy      = st_r.ctrl[sioc_pkg::CTRL_RDY_ALT] ?
                        !st_r.status[sioc_pkg::ST_TX_EMPTY] : st_r.status[sioc_pkg::ST_TX_EMPTY];
    end

    // pin muxing; open-drain drives only a low level on the data and ready pins
    always_comb begin
        if (st_r.ctrl[sioc_pkg::CTRL_SIO_PINS]) begin
            port1_bit5_pin_o    = pins.sout;
            port1_bit5_pin_oe_o = st_r.ctrl[sioc_pkg::CTRL_OPEN_DR] ? !pins.sout : 1'b1;
            port1_bit6_pin_o    = pins.sclk_out;
            port1_bit6_pin_oe_o = pins.sclk_oe;
        end else begin
            port1_bit5_pin_o    = port_dat_i[0];
            port1_bit5_pin_oe_o = port_dir_i[0];
            port1_bit6_pin_o    = port_dat_i[1];
            port1_bit6_pin_oe_o = port_dir_i[1];
        end
        if (st_r.ctrl[sioc_pkg::CTRL_RDY_EN]) begin
            port1_bit7_pin_o    = pins.rdy;
            port1_bit7_pin_oe_o = st_r.ctrl[sioc_pkg::CTRL_OPEN_DR] ? !pins.rdy : 1'b1;
        end else begin
            port1_bit7_pin_o    = port_dat_i[2];
            port1_bit7_pin_oe_o = port_dir_i[2];
        end
    end

    // bus and interrupt outputs
    assign dat_o = st_r.rdat;
    assign ack_o = st_r.ack;
    assign irq_o = |(st_r.ev_st & st_r.ev_en);
endmodule : sioc_top

//--- rtl/sioc_pkg.sv
package sioc_pkg;
    // wishbone byte addresses (word aligned)
    localparam logic [7:0] ADDR_CTRL    = 8'h00;  // serial_port_control
    localparam logic [7:0] ADDR_STATUS  = 8'h04;  // serial_port_status
    localparam logic [7:0] ADDR_TXDATA  = 8'h08;  // transmit buffer
    localparam logic [7:0] ADDR_RXDATA  = 8'h0C;  // receive buffer
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h10;  // sticky event status
    localparam logic [7:0] ADDR_IRQ_EN  = 8'h14;  // event enable
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;  // write-one-to-clear

    // control field positions
    localparam int CTRL_DIV_LSB  = 0;  // two-bit divider select
    localparam int CTRL_INTCLK   = 2;  // 1: internal shift clock
    localparam int CTRL_SIO_PINS = 3;  // 1: pins carry serial out and clock
    localparam int CTRL_RDY_EN   = 4;  // 1: ready pin carries handshake
    localparam int CTRL_RDY_ALT  = 5;  // 1: alternative ready variant
    localparam int CTRL_BYTE_SPC = 6;  // 1: byte specify mode
    localparam int CTRL_OPEN_DR  = 7;  // 1: open-drain data and ready outputs

    // status field positions
    localparam int ST_TX_EMPTY = 0;  // transmit buffer empty
    localparam int ST_RX_FULL  = 1;  // receive buffer full
    localparam int ST_TX_DONE  = 2;  // transmit shift completed
    localparam int ST_OE       = 3;  // overrun error
    localparam int ST_PAR_ERR  = 4;  // parity error
    localparam int ST_FRM_ERR  = 5;  // framing error
    localparam int ST_ANY_ERR  = 6;  // or of the three errors
    localparam int ST_ONE      = 7;  // hard-wired one

    // reset values
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [6:0] STATUS_RESET = 7'h00;

    // divider ratios for codes 00..11
    localparam int DIV_CODE0 = 8;
    localparam int DIV_CODE1 = 16;
    localparam int DIV_CODE2 = 32;
    localparam int DIV_CODE3 = 512;
    localparam int DIV_W     = 9;

    // interrupt event bits
    localparam int EV_TX_DONE = 0;
    localparam int EV_RX_FULL = 1;
    localparam int EV_ERROR   = 2;
    localparam int EV_W       = 3;

    // variant: 0 synchronous only, 1 synchronous and asynchronous
    localparam bit UART_VARIANT = 1'b1;

    // shift engine pin group
    typedef struct packed {
        logic sout;     // serial data out
        logic sclk_out; // shift clock out
        logic sclk_oe;  // internal clock drives the pin
        logic rdy;      // raw ready level (low when armed; high when armed in the alternative variant)
    } sioc_pins_t;

    typedef enum logic [1:0] {SIOC_IDLE, SIOC_SHIFT, SIOC_DONE} sioc_state_t;
endpackage : sioc_pkg

//--- rtl/sioc_div.sv
`timescale 1ns/1ps
// internal shift clock prescaler: one-cycle tick every 8/16/32/512 clocks
module sioc_div (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // control
    input  wire logic [1:0] sel_i,
    input  wire logic       run_i,
    // tick out
    output logic            tick_o
);
    typedef struct packed {
        logic [sioc_pkg::DIV_W-1:0] cnt;
        logic                       tick;
    } sioc_div_st_t;

    sioc_div_st_t st_r;   // state
    sioc_div_st_t st_nxt; // next state

    // map the code to the terminal count
    function automatic logic [sioc_pkg::DIV_W-1:0] sioc_last(input logic [1:0] s);
        case (s)
            2'h0:    sioc_last = 9'(sioc_pkg::DIV_CODE0 - 1);
            2'h1:    sioc_last = 9'(sioc_pkg::DIV_CODE1 - 1);
            2'h2:    sioc_last = 9'(sioc_pkg::DIV_CODE2 - 1);
            default: sioc_last = 9'(sioc_pkg::DIV_CODE3 - 1);
        endcase
    endfunction : sioc_last

    // count up, pulse at terminal count
    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (!run_i) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt >= sioc_last(sel_i)) begin
            st_nxt.cnt  = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 9'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_o = st_r.tick;
endmodule : sioc_div

//--- testbench/sioc_peer.sv
`timescale 1ns/1ps
// serial peer: loops data back and models pulled-up lines
module sioc_peer (
    // pins from the block
    input  wire logic sout_i,
    input  wire logic sout_oe_i,
    input  wire logic sclk_i,
    input  wire logic sclk_oe_i,
    // levels seen by the block
    output logic      sin_o,
    output logic      sclk_o
);
    // a released line floats to the pull-up level, never to the last value
    assign sin_o  = sout_oe_i ? sout_i : 1'b1;
    assign sclk_o = sclk_oe_i ? sclk_i : 1'b1;
endmodule : sioc_peer

//--- testbench/sioc_chk_assertions.sv
`timescale 1ns/1ps
// port checker; keeps its own copy of the control byte from acked writes
module sioc_chk (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // bus
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // pins
    input wire logic        port1_bit5_pin_o,
    input wire logic        port1_bit5_pin_oe_o,
    input wire logic        port1_bit6_pin_oe_o,
    input wire logic        port1_bit7_pin_o,
    input wire logic        port1_bit7_pin_oe_o,
    input wire logic [2:0]  port_dat_i,
    input wire logic [2:0]  port_dir_i,
    input wire logic        irq_o
);
    logic [7:0] ctl_r;   // mirrored control byte
    logic       ack_d_r; // ack one cycle late
    logic       calm;    // no write near, so the mirror is exact except bit 6, which the uart variant clears
    logic       rd_st;   // status read answered
    assign calm  = !ack_o && !ack_d_r;
    assign rd_st = ack_o && !we_i && adr_i == sioc_pkg::ADDR_STATUS;
    // mirror updates at the edge where the master sees ack
    always_ff @(posedge clk_i) begin
        ack_d_r <= ack_o;
        if (rst_i)
            ctl_r <= 8'h00;
        else if (ack_o && we_i && sel_i[0] && adr_i == sioc_pkg::ADDR_CTRL)
            ctl_r <= dat_i[7:0];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack one cycle after request");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !ack_o)
        else $error("irq or ack after reset");
    a_status_one: assert property (rd_st |-> dat_o[7])
        else $error("status bit 7 read low");
    a_error_sum: assert property (rd_st |-> dat_o[6] == |dat_o[5:3])
        else $error("summary error bit wrong");
    a_port_pins: assert property (calm && !ctl_r[3] && !ctl_r[7] |->
        port1_bit5_pin_o == port_dat_i[0] && port1_bit5_pin_oe_o == port_dir_i[0])
        else $error("data pin not an ordinary port");
    a_ready_port: assert property (calm && !ctl_r[4] && !ctl_r[7] |->
        port1_bit7_pin_o == port_dat_i[2] && port1_bit7_pin_oe_o == port_dir_i[2])
        else $error("ready pin not an ordinary port");
    a_ext_clock: assert property (calm && ctl_r[3:2] == 2'b10 |-> !port1_bit6_pin_oe_o)
        else $error("clock pin driven with external clock");
    a_int_clock: assert property (calm && ctl_r[3:2] == 2'b11 |-> port1_bit6_pin_oe_o)
        else $error("clock pin not driven with internal clock");
    a_open_drain: assert property (calm && ctl_r[7] && ctl_r[3] |->
        !(port1_bit5_pin_oe_o && port1_bit5_pin_o))
        else $error("open drain output driven high");
    a_ready_drive: assert property (calm && ctl_r[4] |-> port1_bit7_pin_oe_o || ctl_r[7])
        else $error("ready pin not driven");
    c_ctrl_write: cover property (ack_o && we_i && adr_i == sioc_pkg::ADDR_CTRL);
    c_irq_up: cover property ($rose(irq_o));
    c_status_read: cover property (rd_st && dat_o[6]);
endmodule : sioc_chk

bind sioc_top sioc_chk sioc_chk_i (.*);

//--- testbench/test_sioc_top.sv
`timescale 1ns/1ps
// register, loop-back and pin tests of the serial block
module test_sioc_top;
    localparam logic [7:0] CT = sioc_pkg::ADDR_CTRL;
    localparam logic [7:0] ST = sioc_pkg::ADDR_STATUS;
    localparam logic [7:0] TX = sioc_pkg::ADDR_TXDATA;
    localparam logic [7:0] RX = sioc_pkg::ADDR_RXDATA;
    localparam logic [7:0] IS = sioc_pkg::ADDR_IRQ_ST;
    localparam logic [7:0] IE = sioc_pkg::ADDR_IRQ_EN;
    localparam logic [7:0] IC = sioc_pkg::ADDR_IRQ_CLR;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic ack_o, port1_bit5_pin_o, port1_bit5_pin_oe_o, port1_bit6_pin_i, sin_i, irq_o;
    logic port1_bit6_pin_o, port1_bit6_pin_oe_o, port1_bit7_pin_o, port1_bit7_pin_oe_o;
    logic parity_err_i = 0, framing_err_i = 0;
    logic [2:0] port_dat_i = 3'h5, port_dir_i = 3'h3;
    logic [7:0] rd;                       // last read byte
    int errors = 0, compares = 0;
    int rat [4] = '{8, 16, 32, 512};      // half period per divider code
    always #10 clk_i = ~clk_i;
    sioc_top sioc_top_i (.*);
    sioc_peer sioc_peer_i (.sout_i(port1_bit5_pin_o), .sout_oe_i(port1_bit5_pin_oe_o),
        .sclk_i(port1_bit6_pin_o), .sclk_oe_i(port1_bit6_pin_oe_o), .sin_o(sin_i),
        .sclk_o(port1_bit6_pin_i));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one classic cycle; ack and data are taken at the rising edge, then released
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge clk_i);
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; sel_i <= 4'hF; dat_i <= {24'h0, d};
        k = 0;
        do begin @(posedge clk_i); k++; end while (ack_o !== 1'b1 && k < 50);
        if (k >= 50) chk(0, 1);
        rd = dat_o[7:0];
        cyc_i <= 0; stb_i <= 0; we_i <= 0;
    endtask : wb
    task rdchk(input logic [7:0] a, input logic [7:0] e);
        wb(0, a, 8'h00);
        chk(rd, e);
    endtask : rdchk
    // count negedges while the shift clock holds its level
    task hold(output int k);
        logic lv;
        lv = port1_bit6_pin_o;
        k = 0;
        while (port1_bit6_pin_o === lv && k < 2000) begin @(negedge clk_i); k++; end
    endtask : hold
    // send one byte, time a half period, wait for shift completion
    task xfer(input logic [7:0] d, input int r);
        int k;
        wb(1, TX, d);
        hold(k);
        hold(k);
        chk(k, r);
        k = 0;
        do begin wb(0, ST, 8'h00); k++; end while (rd[2] !== 1'b1 && k < 4000);
    endtask : xfer
    task irq_is(input logic v);
        repeat (2) @(negedge clk_i);
        chk(irq_o, v);
    endtask : irq_is
    task complete_run;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    // watchdog well beyond the longest transfer
    initial begin
        repeat (90000) @(posedge clk_i);
        errors++;
        complete_run;
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        rdchk(CT, 8'h00);
        rdchk(ST, 8'h80);
        wb(1, ST, 8'h7F);
        rdchk(ST, 8'h80);
        rdchk(8'h1C, 8'h00);
        wb(1, CT, 8'hFF);
        rdchk(CT, 8'hBF);
        wb(1, CT, 8'h00);
        chk({port1_bit7_pin_oe_o, port1_bit7_pin_o, port1_bit5_pin_oe_o, port1_bit5_pin_o},
            {port_dir_i[2], port_dat_i[2], port_dir_i[0], port_dat_i[0]});
        $display("test registers done");
        wb(1, IE, 8'h07);
        for (int c = 0; c < 4; c++) begin
            wb(1, CT, 8'h0C | 8'(c));
            xfer(8'h5A ^ 8'(c), rat[c]);
            chk(rd, 8'h87);
            irq_is(1'b1);
            rdchk(RX, 8'h5A ^ 8'(c));
            rdchk(ST, 8'h85);
            wb(1, IC, 8'h07);
            irq_is(1'b0);
        end
        $display("test dividers done");
        // masked events: overrun, then parity and framing
        wb(1, IE, 8'h00);
        wb(1, CT, 8'h0C);
        xfer(8'h11, 8);
        xfer(8'h22, 8);
        rdchk(ST, 8'hCF);
        irq_is(1'b0);
        rdchk(IS, 8'h07);
        rdchk(RX, 8'h22);
        rdchk(ST, 8'h85);
        @(posedge clk_i);
        parity_err_i <= 1; framing_err_i <= 1;
        @(posedge clk_i);
        parity_err_i <= 0; framing_err_i <= 0;
        rdchk(ST, 8'hF5);
        wb(1, IE, 8'h04);
        irq_is(1'b1);
        rdchk(RX, 8'h22);
        wb(1, IC, 8'h07);
        irq_is(1'b0);
        $display("test errors done");
        // ready variants, open drain and external clock
        wb(1, CT, 8'h18);
        chk({port1_bit7_pin_oe_o, port1_bit7_pin_o}, 2'b11);
        wb(1, CT, 8'h38);
        chk({port1_bit7_pin_oe_o, port1_bit7_pin_o}, 2'b10);
        wb(1, CT, 8'h98);
        chk(port1_bit7_pin_oe_o, 1'b0);
        wb(1, CT, 8'h08);
        chk(port1_bit6_pin_oe_o, 1'b0);
        $display("test pins done");
        complete_run;
    end
endmodule : test_sioc_top
